// file: core/mdv_defines.vh
// constants for the memory-mapped multiply/divide unit
`ifndef MDV_DEFINES_VH
`define MDV_DEFINES_VH

// register byte addresses on the register bus
`define MDV_ADDR_W 8
`define MDV_OFS_OPERAND_0 8'h00
`define MDV_OFS_OPERAND_1 8'h04
`define MDV_OFS_OPERAND_2 8'h08
`define MDV_OFS_OPERAND_3 8'h0C
`define MDV_OFS_OPERAND_4 8'h10
`define MDV_OFS_OPERAND_5 8'h14
`define MDV_OFS_STATUS 8'h18

// status register layout
`define MDV_STAT_ERR_BIT 7
`define MDV_STAT_OVF_BIT 6
`define MDV_STATUS_RST 8'h00

// bus response codes
`define MDV_RESP_OKAY 2'h0
`define MDV_RESP_SLVERR 2'h2

// timing: clock period and calculation times in system clock periods
`define MDV_CLK_PERIOD_NS 100
`define MDV_SYS_PERIOD_NS 100
`define MDV_LONG_DIV_SYSTEM_CLOCK_PERIOD 17
`define MDV_SHORT_DIV_SYSTEM_CLOCK_PERIOD 9
`define MDV_MUL_SYSTEM_CLOCK_PERIOD 11
// system clock period equals the bus clock period: one count per clock
`define MDV_LONG_DIV_CYC 5'h11
`define MDV_SHORT_DIV_CYC 5'h09
`define MDV_MUL_CYC 5'h0B

`endif

// file: core/mdv_muldiv_unit.v
// multiply/divide unit with write-order operation select and AXI4-Lite slave
`timescale 1ns/100ps
`include "mdv_defines.vh"

module mdv_muldiv_unit
(
   input wire clk_in,
   input wire srst_in,
   input wire [7:0] s_axi_awaddr_in,
   input wire [2:0] s_axi_awprot_in,
   input wire s_axi_awvalid_in,
   output reg s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output reg s_axi_wready_out,
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire [7:0] s_axi_araddr_in,
   input wire [2:0] s_axi_arprot_in,
   input wire s_axi_arvalid_in,
   output reg s_axi_arready_out,
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,
   output reg busy_out
);

   // -----------------------------------------------------------------
   // write order states
   // -----------------------------------------------------------------
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_W0 = 4'h1;
   localparam [3:0] ST_W01 = 4'h2;
   localparam [3:0] ST_W012 = 4'h3;
   localparam [3:0] ST_W0123 = 4'h4;
   localparam [3:0] ST_W01234 = 4'h5;
   localparam [3:0] ST_W014 = 4'h6;
   localparam [3:0] ST_W04 = 4'h7;
   localparam [3:0] ST_W041 = 4'h8;

   localparam [1:0] OP_LONG = 2'h0;
   localparam [1:0] OP_SHORT = 2'h1;
   localparam [1:0] OP_MUL = 2'h2;

   localparam [4:0] CYC_LONG = `MDV_LONG_DIV_CYC;
   localparam [4:0] CYC_SHORT = `MDV_SHORT_DIV_CYC;
   localparam [4:0] CYC_MUL = `MDV_MUL_CYC;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   reg [7:0] op_q [0:5];
   reg [3:0] seq_q;
   reg [1:0] kind_q;
   reg [4:0] cnt_q;
   reg err_q;
   reg ovf_q;
   reg [7:0] aw_addr_q;
   reg aw_have_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_have_q;
   integer i;

   // -----------------------------------------------------------------
   // access decode
   // -----------------------------------------------------------------
   wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_out;
   wire rd_fire = s_axi_arvalid_in && s_axi_arready_out;
   reg wr_is_op;
   reg wr_is_stat;
   reg [2:0] wr_idx;
   reg rd_is_op;
   reg rd_is_stat;
   reg [2:0] rd_idx;

   always @*
   begin
      {wr_is_op, wr_is_stat, wr_idx} = 5'h00;
      if (aw_addr_q == `MDV_OFS_OPERAND_0)
         {wr_is_op, wr_idx} = {1'b1, 3'h0};
      else if (aw_addr_q == `MDV_OFS_OPERAND_1)
         {wr_is_op, wr_idx} = {1'b1, 3'h1};
      else if (aw_addr_q == `MDV_OFS_OPERAND_2)
         {wr_is_op, wr_idx} = {1'b1, 3'h2};
      else if (aw_addr_q == `MDV_OFS_OPERAND_3)
         {wr_is_op, wr_idx} = {1'b1, 3'h3};
      else if (aw_addr_q == `MDV_OFS_OPERAND_4)
         {wr_is_op, wr_idx} = {1'b1, 3'h4};
      else if (aw_addr_q == `MDV_OFS_OPERAND_5)
         {wr_is_op, wr_idx} = {1'b1, 3'h5};
      else if (aw_addr_q == `MDV_OFS_STATUS)
         wr_is_stat = 1'b1;
   end

   always @*
   begin
      {rd_is_op, rd_is_stat, rd_idx} = 5'h00;
      if (s_axi_araddr_in == `MDV_OFS_OPERAND_0)
         {rd_is_op, rd_idx} = {1'b1, 3'h0};
      else if (s_axi_araddr_in == `MDV_OFS_OPERAND_1)
         {rd_is_op, rd_idx} = {1'b1, 3'h1};
      else if (s_axi_araddr_in == `MDV_OFS_OPERAND_2)
         {rd_is_op, rd_idx} = {1'b1, 3'h2};
      else if (s_axi_araddr_in == `MDV_OFS_OPERAND_3)
         {rd_is_op, rd_idx} = {1'b1, 3'h3};
      else if (s_axi_araddr_in == `MDV_OFS_OPERAND_4)
         {rd_is_op, rd_idx} = {1'b1, 3'h4};
      else if (s_axi_araddr_in == `MDV_OFS_OPERAND_5)
         {rd_is_op, rd_idx} = {1'b1, 3'h5};
      else if (s_axi_araddr_in == `MDV_OFS_STATUS)
         rd_is_stat = 1'b1;
   end

   // -----------------------------------------------------------------
   // arithmetic on held operands
   // -----------------------------------------------------------------
   // operands are frozen while busy, so results are settled by completion
   wire [31:0] long_dvd = {op_q[3], op_q[2], op_q[1], op_q[0]};
   wire [15:0] short_dvd = {op_q[1], op_q[0]};
   wire [15:0] divisor = {op_q[5], op_q[4]};
   wire div_zero = (divisor == 16'h0000);
   wire [15:0] safe_dvs = div_zero ? 16'h0001 : divisor;
   wire [31:0] long_quo = long_dvd / {16'h0000, safe_dvs};
   wire [31:0] long_rem = long_dvd % {16'h0000, safe_dvs};
   wire [15:0] short_quo = short_dvd / safe_dvs;
   wire [15:0] short_rem = short_dvd % safe_dvs;
   wire [31:0] product = {16'h0000, short_dvd} * {16'h0000, divisor};

   wire busy = (cnt_q != 5'h00);
   wire done = (cnt_q == 5'h01);
   wire s_axi_wstrb_ok = w_strb_q[0];
   wire wr_op_ok = wr_fire && wr_is_op && s_axi_wstrb_ok && !busy;

   // -----------------------------------------------------------------
   // operands, order tracking, calculation, flags
   // -----------------------------------------------------------------
   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         for (i = 0; i < 6; i = i + 1)
            op_q[i] <= 8'h00;
         seq_q <= ST_IDLE;
         kind_q <= OP_LONG;
         cnt_q <= 5'h00;
         err_q <= 1'b0;
         ovf_q <= 1'b0;
         busy_out <= 1'b0;
      end
      else
      begin
         busy_out <= busy && !done;
         if (busy)
            cnt_q <= cnt_q - 5'h01;
         // set wins: clear only allowed while idle, set only while busy
         if ((wr_fire && wr_is_op && busy) || (rd_fire && rd_is_op && busy))
            err_q <= 1'b1;
         else if (rd_fire && rd_is_stat && err_q && !busy)
            err_q <= 1'b0;
         if (wr_op_ok)
         begin
            op_q[wr_idx] <= w_data_q[7:0];
            // only operand writes and completion move the order; all else leaves it be
            if (wr_idx == 3'h0)
               seq_q <= ST_W0;
            else
            begin
               seq_q <= ST_IDLE;
               case (seq_q)
                  ST_W0:
                  begin
                     if (wr_idx == 3'h1)
                        seq_q <= ST_W01;
                     else if (wr_idx == 3'h4)
                        seq_q <= ST_W04;
                  end
                  ST_W01:
                  begin
                     if (wr_idx == 3'h2)
                        seq_q <= ST_W012;
                     else if (wr_idx == 3'h4)
                        seq_q <= ST_W014;
                  end
                  ST_W012:
                  begin
                     if (wr_idx == 3'h3)
                        seq_q <= ST_W0123;
                  end
                  ST_W0123:
                  begin
                     if (wr_idx == 3'h4)
                        seq_q <= ST_W01234;
                  end
                  ST_W04:
                  begin
                     if (wr_idx == 3'h1)
                        seq_q <= ST_W041;
                  end
                  default:
                  begin
                     seq_q <= ST_IDLE;
                  end
               endcase
               if (wr_idx == 3'h5)
               begin
                  // a stray operand 5 write just lands in the register
                  if (seq_q == ST_W01234)
                  begin
                     kind_q <= OP_LONG;
                     cnt_q <= CYC_LONG;
                     busy_out <= 1'b1;
                  end
                  else if (seq_q == ST_W014)
                  begin
                     kind_q <= OP_SHORT;
                     cnt_q <= CYC_SHORT;
                     busy_out <= 1'b1;
                  end
                  else if (seq_q == ST_W041)
                  begin
                     kind_q <= OP_MUL;
                     cnt_q <= CYC_MUL;
                     busy_out <= 1'b1;
                  end
               end
            end
         end
         if (done)
         begin
            seq_q <= ST_IDLE;
            case (kind_q)
               OP_LONG:
               begin
                  ovf_q <= div_zero;
                  if (!div_zero)
                  begin
                     {op_q[3], op_q[2], op_q[1], op_q[0]} <= long_quo;
                     {op_q[5], op_q[4]} <= long_rem[15:0];
                  end
               end
               OP_SHORT:
               begin
                  ovf_q <= div_zero;
                  if (!div_zero)
                  begin
                     {op_q[1], op_q[0]} <= short_quo;
                     {op_q[5], op_q[4]} <= short_rem;
                  end
               end
               default:
               begin
                  ovf_q <= (product[31:16] != 16'h0000);
                  {op_q[3], op_q[2], op_q[1], op_q[0]} <= product;
               end
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite write channels
   // -----------------------------------------------------------------
   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out <= 1'b1;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `MDV_RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid_in && s_axi_awready_out)
         begin
            aw_addr_q <= {s_axi_awaddr_in[7:2], 2'b00};
            aw_have_q <= 1'b1;
            s_axi_awready_out <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out)
         begin
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
            w_have_q <= 1'b1;
            s_axi_wready_out <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            // status is read-only; writes to it are silently dropped
            if (wr_is_op || wr_is_stat)
               s_axi_bresp_out <= `MDV_RESP_OKAY;
            else
               s_axi_bresp_out <= `MDV_RESP_SLVERR;
         end
         if (s_axi_bvalid_out && s_axi_bready_in)
         begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite read channels
   // -----------------------------------------------------------------
   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h00000000;
         s_axi_rresp_out <= `MDV_RESP_OKAY;
      end
      else
      begin
         if (rd_fire)
         begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= `MDV_RESP_OKAY;
            s_axi_rdata_out <= 32'h00000000;
            // reads have no side effect on results, any order is safe
            if (rd_is_op)
               s_axi_rdata_out <= {24'h000000, op_q[rd_idx]};
            else if (rd_is_stat)
               s_axi_rdata_out <= {24'h000000, err_q, ovf_q, 6'b000000};
            else
               s_axi_rresp_out <= `MDV_RESP_SLVERR;
         end
         if (s_axi_rvalid_out && s_axi_rready_in)
         begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
         end
      end
   end

endmodule

// file: test/mdv_muldiv_unit_chk.sv
// port checker for the multiply/divide unit
`timescale 1ns/100ps
module mdv_muldiv_chk
(
   input wire clk_in,
   input wire srst_in,
   input wire s_axi_awvalid_in,
   input wire s_axi_awready_out,
   input wire s_axi_wvalid_in,
   input wire s_axi_wready_out,
   input wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire s_axi_arvalid_in,
   input wire s_axi_arready_out,
   input wire [31:0] s_axi_rdata_out,
   input wire s_axi_rvalid_out,
   input wire s_axi_rready_in,
   input wire busy_out
);
   // --------------------------
   // busy length counter
   // --------------------------
   reg [4:0] cnt_q;
   always @(posedge clk_in)
      if (srst_in || !busy_out)
         cnt_q <= 5'h00;
      else
         cnt_q <= cnt_q + 5'h01;

   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);

   sequence b_late_s;
      !s_axi_bvalid_out ##1 s_axi_bvalid_out;
   endsequence

   b_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out |=> b_late_s) else $error("write response not two edges late");
   b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
      else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
      && $stable(s_axi_rdata_out)) else $error("read data dropped");
   r_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   rdata_zero_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
      else $error("read data upper bits set");
   ready_low_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write ready while response pending");
   busy_start_a: assert property ($rose(busy_out) |-> $rose(s_axi_bvalid_out))
      else $error("calculation started without a write");
   busy_len_a: assert property ($fell(busy_out) |->
      cnt_q == 5'h09 || cnt_q == 5'h0B || cnt_q == 5'h11)
      else $error("calculation length wrong");
   busy_bound_a: assert property (busy_out |-> cnt_q < 5'h11)
      else $error("calculation too long");
endmodule

bind mdv_muldiv_unit mdv_muldiv_chk i_chk (.clk_in(clk_in), .srst_in(srst_in),
   .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
   .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
   .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
   .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
   .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
   .s_axi_rready_in(s_axi_rready_in), .busy_out(busy_out));

// file: test/mdv_muldiv_unit_bench.sv
// self-checking bench for the multiply/divide unit
`timescale 1ns/100ps
`include "mdv_defines.vh"
module mdv_muldiv_unit_bench;
   reg clk_in = 1'b0;
   reg srst_in = 1'b1;
   reg [7:0] awa = 8'h00;
   reg [7:0] ara = 8'h00;
   reg [31:0] wd = 32'h00000000;
   reg awv = 1'b0;
   reg wv = 1'b0;
   reg bry = 1'b0;
   reg arv = 1'b0;
   reg rry = 1'b0;
   wire awrdy, wrdy, bval, arrdy, rval, busy;
   wire [1:0] bresp, rresp;
   wire [31:0] rdat;
   reg [7:0] m [0:5];
   reg [1:0] rsp;
   reg [31:0] got;
   reg err = 1'b0;
   reg ov = 1'b0;
   reg bsy = 1'b0;
   integer n_mismatch = 0;
   integer total_checks = 0;
   integer k;

   always #50 clk_in = ~clk_in;

   mdv_muldiv_unit i_dut (.clk_in(clk_in), .srst_in(srst_in), .s_axi_awaddr_in(awa),
      .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awv), .s_axi_awready_out(awrdy),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bval),
      .s_axi_bready_in(bry), .s_axi_araddr_in(ara), .s_axi_arprot_in(3'h0),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arrdy), .s_axi_rdata_out(rdat),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rval), .s_axi_rready_in(rry),
      .busy_out(busy));

   // --------------------------
   // bus and compare tasks
   // --------------------------
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask

   // no cycle budget in the bus tasks: only the watchdog ends a stalled wait
   task bus_wr(input [7:0] a, input [7:0] d);
      reg ans;
      begin
         @(posedge clk_in);
         awa <= a;
         wd <= {24'h000000, d};
         awv <= 1'b1;
         wv <= 1'b1;
         bry <= 1'b1;
         ans = 1'b0;
         while (!ans)
         begin
            @(posedge clk_in);
            if (awv && awrdy)
               awv <= 1'b0;
            if (wv && wrdy)
               wv <= 1'b0;
            if (bval === 1'b1)
            begin
               rsp = bresp;
               ans = 1'b1;
            end
         end
         bry <= 1'b0;
      end
   endtask

   task bus_rd(input [7:0] a);
      reg ans;
      begin
         @(posedge clk_in);
         ara <= a;
         arv <= 1'b1;
         rry <= 1'b1;
         ans = 1'b0;
         while (!ans)
         begin
            @(posedge clk_in);
            if (arv && arrdy)
               arv <= 1'b0;
            if (rval === 1'b1)
            begin
               got = rdat;
               rsp = rresp;
               ans = 1'b1;
            end
         end
         rry <= 1'b0;
      end
   endtask

   // writes while calculating are dropped but flag an error
   task put(input [7:0] i, input [7:0] d);
      begin
         bus_wr({i[5:0], 2'h0}, d);
         if (bsy)
            err = 1'b1;
         else
            m[i] = d;
      end
   endtask

   task chkall;
      begin
         bus_rd(`MDV_OFS_STATUS);
         chk(got, {24'h000000, err, ov, 6'h00});
         err = 1'b0;
         for (k = 0; k < 6; k = k + 1)
         begin
            bus_rd(k * 4);
            chk(got, {24'h000000, m[k]});
         end
      end
   endtask

   // unmapped reads between operand writes must not break the order
   task seq(input integer n, input [95:0] t);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1)
         begin
            put(t[95-16*i -: 8], t[87-16*i -: 8]);
            bus_rd(8'h1C);
            chk({30'h0, rsp}, {30'h0, `MDV_RESP_SLVERR});
         end
      end
   endtask

   task go;
      begin
         chk({31'h0, busy}, 32'h1);
         bsy = 1'b1;
      end
   endtask

   task fin(input [1:0] kd);
      reg [31:0] dd;
      reg [31:0] q;
      reg [15:0] dv;
      begin
         while (busy !== 1'b0)
            @(posedge clk_in);
         dd = {m[3], m[2], m[1], m[0]};
         dv = {m[5], m[4]};
         if (kd == 2'h2)
         begin
            dd = {m[1], m[0]} * dv;
            ov = dd > 32'h0000FFFF;
            {m[3], m[2], m[1], m[0]} = dd;
         end
         else
         begin
            if (kd == 2'h1)
               dd = {16'h0000, m[1], m[0]};
            ov = dv == 16'h0000;
            if (!ov)
            begin
               q = dd / dv;
               {m[5], m[4]} = dd % dv;
               {m[1], m[0]} = q[15:0];
               if (kd == 2'h0)
                  {m[3], m[2]} = q[31:16];
            end
         end
         bsy = 1'b0;
         chkall;
      end
   endtask

   task conclude;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_mismatch);
         if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   initial
   begin
      #1000000;
      n_mismatch = n_mismatch + 1;
      conclude;
   end

   initial
   begin
      for (k = 0; k < 6; k = k + 1)
         m[k] = 8'h00;
      repeat (8) @(posedge clk_in);
      srst_in <= 1'b0;
      chkall;
      seq(6, {16'h0078, 16'h0156, 16'h0234, 16'h0312, 16'h0434, 16'h0512});
      go;
      fin(2'h0);
      seq(4, {16'h00CD, 16'h01AB, 16'h0412, 16'h0500, 32'h0});
      go;
      fin(2'h1);
      seq(6, {16'h0034, 16'h0199, 16'h0034, 16'h04FF, 16'h0112, 16'h0500});
      go;
      fin(2'h2);
      seq(4, {16'h0010, 16'h0420, 16'h0100, 16'h0500, 32'h0});
      go;
      bus_rd(8'h00);
      chk(got, {24'h000000, m[0]});
      err = 1'b1;
      put(3, 8'hEE);
      fin(2'h2);
      chkall;
      seq(4, {16'h0001, 16'h0102, 16'h0400, 16'h0500, 32'h0});
      go;
      fin(2'h1);
      seq(3, {16'h0007, 16'h0208, 16'h0509, 48'h0});
      chk({31'h0, busy}, 32'h0);
      bus_wr(`MDV_OFS_STATUS, 8'hFF);
      chkall;
      bus_wr(8'h1C, 8'h55);
      chk({30'h0, rsp}, {30'h0, `MDV_RESP_SLVERR});
      conclude;
   end
endmodule
